// [pie_pkg.sv]
// Constants, source table and carrier types of the peripheral interrupt expander
// Behaviour
// [R1] Reset outranks all, unmaskable, vector 0000h
// [R2] Pin irqs a/b: line one, 0001h/0011h
// [R3] Serial rx/tx: line one, 0006h/0007h
// [R4] Timer a period: line two, 0027h
// [R5] Timer a compare: line two, 0028h
// [R6] Timer a under/overflow: line two, 0029h/002Ah
// [R7] Timer b period: line three, 002Bh
// [R8] Timer b compare: line three, 002Ch
// [R9] Timer b under/overflow: line three, 002Dh/002Eh
// [R10] Compare units line two; captures line four
// [R11] Smallest priority number wins at acknowledge
// [R12] Request equals flag gated by enable
// [R13] Core request: two-cycle low pulse on activation
// [R14] Still active after acknowledge: pulse again
// [R15] Acknowledge with nothing pending loads 0000h
package pie_pkg;
  localparam int NUM_SRC = 20;
  localparam int NUM_LINES = 4;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] PHANTOM_CODE = 16'h0000;
  localparam logic [1:0] PULSE_CYCLES = 2'h2;
  // Program address seen on acknowledge, one per core line
  localparam logic [15:0] LINE_ADDR [NUM_LINES] = '{16'h0002, 16'h0004, 16'h0006, 16'h0008};
  // Index is the request bit (0.0 .. 0.15, then 1.0 .. 1.3) and the priority order
  localparam logic [1:0] SRC_LINE [NUM_SRC] = '{
    2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
    2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
    2'h2, 2'h2, 2'h2, 2'h2,
    2'h3, 2'h3, 2'h3};
  localparam logic [15:0] SRC_CODE [NUM_SRC] = '{
    16'h0020, 16'h0004,
    16'h0001, 16'h0011, // R2
    16'h0006, 16'h0007, // R3
    16'h0021, 16'h0022, 16'h0023, // R10
    16'h0027, // R4
    16'h0028, // R5
    16'h0029, 16'h002A, // R6
    16'h002B, // R7
    16'h002C, // R8
    16'h002D, 16'h002E, // R9
    16'h0033, 16'h0034, 16'h0035}; // R10
  typedef struct packed {
    logic [NUM_SRC-1:0] flag;
    logic [NUM_SRC-1:0] enable;
  } source_bus_t;
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } ack_bus_t;
endpackage

// [peripheral_irq_expander.sv]
// Peripheral interrupt expander: request pulses, priority pick and vector register
`timescale 1ns/1ns
module peripheral_irq_expander (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire pie_pkg::source_bus_t src_i,
  input wire pie_pkg::ack_bus_t ack_i,
  output logic [pie_pkg::NUM_SRC-1:0] pending_request_bits_o,
  output logic [pie_pkg::NUM_SRC-1:0] acknowledge_bits_o,
  output logic [15:0] source_vector_register_o,
  output logic [pie_pkg::NUM_LINES-1:0] line_req_b_o,
  output logic [15:0] boot_vector_o
);
  localparam int NS = pie_pkg::NUM_SRC;
  localparam int NL = pie_pkg::NUM_LINES;

  // Returns {found, index} of the lowest-numbered pending source on a line
  function automatic logic [5:0] pick_src(input logic [NS-1:0] pend, input logic [1:0] line);
    logic [5:0] r;
    r = 6'h00;
    for (int i = NS - 1; i >= 0; i--) begin
      if (pend[i] && pie_pkg::SRC_LINE[i] == line) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // Returns {hit, line} for the program address shown on acknowledge
  function automatic logic [2:0] decode_line(input logic [15:0] addr);
    logic [2:0] r;
    r = 3'h0;
    for (int l = 0; l < NL; l++) begin
      if (addr == pie_pkg::LINE_ADDR[l]) begin
        r = {1'b1, 2'(l)};
      end
    end
    return r;
  endfunction

  logic [NS-1:0] pend;
  logic [NL-1:0] line_any;
  logic [2:0] ack_dec;
  logic ack_hit;
  logic [1:0] ack_line;
  logic [5:0] pick;

  // Combinational so a cleared flag drops its request at once
  assign pend = src_i.flag & src_i.enable; // R12
  assign pending_request_bits_o = pend;
  assign ack_dec = decode_line(ack_i.addr);
  assign ack_hit = ack_i.valid & ack_dec[2];
  assign ack_line = ack_dec[1:0];
  assign pick = pick_src(pend, ack_line); // R11

  always_comb begin
    line_any = '0;
    for (int i = 0; i < NS; i++) begin
      if (pend[i]) begin
        line_any[pie_pkg::SRC_LINE[i]] = 1'b1;
      end
    end
  end

  // Acknowledge side: vector register and clear strobes
  logic [15:0] vec_q, vec_d;
  logic [NS-1:0] ackbits_q, ackbits_d;
  logic [NL-1:0] ack_seen_q, ack_seen_d;

  always_comb begin
    vec_d = vec_q;
    ackbits_d = '0;
    ack_seen_d = '0;
    if (ack_hit) begin
      ack_seen_d[ack_line] = 1'b1;
      if (pick[5]) begin
        vec_d = pie_pkg::SRC_CODE[pick[4:0]]; // R11
        ackbits_d[pick[4:0]] = 1'b1;
      end else begin
        // Flag cleared before the acknowledge, or a software trap to this line
        vec_d = pie_pkg::PHANTOM_CODE; // R15
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vec_q <= pie_pkg::RESET_VECTOR; // R1
      ackbits_q <= '0;
      ack_seen_q <= '0;
    end else begin
      vec_q <= vec_d;
      ackbits_q <= ackbits_d;
      ack_seen_q <= ack_seen_d;
    end
  end

  assign source_vector_register_o = vec_q;
  assign acknowledge_bits_o = ackbits_q;

  // Request side: one two-cycle low pulse per line
  logic [NL-1:0] any_prev_q, any_prev_d;
  logic [NL-1:0][1:0] cnt_q, cnt_d;
  logic [NL-1:0] req_b_q, req_b_d;
  logic [NL-1:0] trig;
  logic [NL-1:0] line_left;

  // The source cleared by its own strobe would otherwise re-request once, as a phantom
  always_comb begin
    line_left = '0;
    for (int i = 0; i < NS; i++) begin
      if (pend[i] && !ackbits_q[i]) begin
        line_left[pie_pkg::SRC_LINE[i]] = 1'b1;
      end
    end
  end

  always_comb begin
    any_prev_d = line_any;
    for (int l = 0; l < NL; l++) begin
      trig[l] = (line_any[l] & ~any_prev_q[l]) | (ack_seen_q[l] & line_left[l]); // R14
      // A trigger inside a running pulse is folded into it: the core sees one request
      if (cnt_q[l] == 2'h0) begin
        cnt_d[l] = trig[l] ? pie_pkg::PULSE_CYCLES : 2'h0; // R13
      end else begin
        cnt_d[l] = cnt_q[l] - 2'h1;
      end
      req_b_d[l] = (cnt_d[l] == 2'h0);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      any_prev_q <= '0;
      cnt_q <= '0;
      req_b_q <= '1; // R1
    end else begin
      any_prev_q <= any_prev_d;
      cnt_q <= cnt_d;
      req_b_q <= req_b_d;
    end
  end

  assign line_req_b_o = req_b_q;
  // Reset is never masked: the core always restarts from this address
  assign boot_vector_o = pie_pkg::RESET_VECTOR; // R1

  // Checks
  property p_reset_quiet;
    @(posedge clk_i) $rose(rst_b_i) |-> line_req_b_o == '1 && source_vector_register_o == 16'h0000;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("not idle after reset"); // R1

  property p_ext_pin;
    @(posedge clk_i) disable iff (!rst_b_i)
      ack_i.valid && ack_i.addr == 16'h0002 && pend[2] && !(|pend[1:0])
      |=> source_vector_register_o == 16'h0001;
  endproperty
  a_ext_pin: assert property (p_ext_pin) else $error("pin irq code wrong"); // R2

  property p_serial;
    @(posedge clk_i) disable iff (!rst_b_i)
      ack_i.valid && ack_i.addr == 16'h0002 && pend[5] && !(|pend[4:0])
      |=> source_vector_register_o == 16'h0007 && acknowledge_bits_o[5];
  endproperty
  a_serial: assert property (p_serial) else $error("serial tx code wrong"); // R3

  property p_timer_a;
    @(posedge clk_i) disable iff (!rst_b_i)
      ack_i.valid && ack_i.addr == 16'h0004 && pend[9] && !(|pend[8:6])
      |=> source_vector_register_o == 16'h0027;
  endproperty
  a_timer_a: assert property (p_timer_a) else $error("timer a period code wrong"); // R4

  property p_timer_b;
    @(posedge clk_i) disable iff (!rst_b_i)
      ack_i.valid && ack_i.addr == 16'h0006 && pend[16] && !(|pend[15:13])
      |=> source_vector_register_o == 16'h002E;
  endproperty
  a_timer_b: assert property (p_timer_b) else $error("timer b overflow code wrong"); // R9

  property p_timer_a_cmp;
    @(posedge clk_i) disable iff (!rst_b_i)
      ack_i.valid && ack_i.addr == 16'h0004 && pend[10] && !(|pend[9:6])
      |=> source_vector_register_o == 16'h0028 && acknowledge_bits_o[10];
  endproperty
  a_timer_a_cmp: assert property (p_timer_a_cmp) else $error("timer a compare code wrong"); // R5

  property p_timer_b_per;
    @(posedge clk_i) disable iff (!rst_b_i)
      ack_i.valid && ack_i.addr == 16'h0006 && pend[13]
      |=> source_vector_register_o == 16'h002B && acknowledge_bits_o[13];
  endproperty
  a_timer_b_per: assert property (p_timer_b_per) else $error("timer b period code wrong"); // R7

  property p_capture;
    @(posedge clk_i) disable iff (!rst_b_i)
      ack_i.valid && ack_i.addr == 16'h0008 && pend[17]
      |=> source_vector_register_o == 16'h0033 && acknowledge_bits_o[17];
  endproperty
  a_capture: assert property (p_capture) else $error("capture code wrong"); // R10

  property p_pick;
    @(posedge clk_i) disable iff (!rst_b_i)
      ack_hit && pick[5] |=> $onehot(acknowledge_bits_o)
        && acknowledge_bits_o[$past(pick[4:0])]
        && source_vector_register_o == pie_pkg::SRC_CODE[$past(pick[4:0])];
  endproperty
  a_pick: assert property (p_pick) else $error("priority pick wrong"); // R11

  property p_gate;
    @(posedge clk_i) disable iff (!rst_b_i)
      (acknowledge_bits_o & ~$past(pending_request_bits_o)) == '0;
  endproperty
  a_gate: assert property (p_gate) else $error("clear strobe to a source not requesting"); // R12

  property p_pulse;
    @(posedge clk_i) disable iff (!rst_b_i)
      $fell(line_req_b_o[0]) |=> !line_req_b_o[0] ##1 line_req_b_o[0];
  endproperty
  a_pulse: assert property (p_pulse) else $error("request pulse not two cycles"); // R13

  property p_retrig;
    @(posedge clk_i) disable iff (!rst_b_i)
      ack_seen_q[1] && line_left[1] && cnt_q[1] == 2'h0 |=> !line_req_b_o[1];
  endproperty
  a_retrig: assert property (p_retrig) else $error("no repeat request"); // R14

  property p_phantom;
    @(posedge clk_i) disable iff (!rst_b_i)
      ack_hit && !pick[5] |=> source_vector_register_o == 16'h0000 && acknowledge_bits_o == '0;
  endproperty
  a_phantom: assert property (p_phantom) else $error("phantom code not loaded"); // R15

  c_phantom: cover property (@(posedge clk_i) disable iff (!rst_b_i) ack_hit && !pick[5]);
  c_retrig: cover property (@(posedge clk_i) disable iff (!rst_b_i) ack_seen_q[0] && trig[0]);
  c_capture: cover property (@(posedge clk_i) disable iff (!rst_b_i) ack_hit && ack_line == 2'h3
    && pick[5]);
endmodule

// [core_model.sv]
// Core side: catches request pulses, acknowledges each after a set wait
`timescale 1ns/1ns
module core_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] line_req_b_i,
  input wire logic [3:0] wait_i,
  output pie_pkg::ack_bus_t ack_o
);
  logic [3:0] seen_q;
  logic [3:0] prev_q;
  logic [3:0] cnt_q;
  logic [3:0] s;
  int k;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seen_q <= 4'h0;
      prev_q <= 4'hF;
      cnt_q <= 4'h0;
      ack_o <= '0;
    end else begin
      // Falling edge only, so one pulse earns one acknowledge
      s = seen_q | (prev_q & ~line_req_b_i);
      prev_q <= line_req_b_i;
      ack_o.valid <= 1'b0;
      cnt_q <= (s == 4'h0) ? 4'h0 : cnt_q + 4'h1;
      if (s != 4'h0 && cnt_q >= wait_i) begin
        // Line one outranks the others at the core
        for (k = 0; k < 4; k++) if (s[k]) break;
        s[k] = 1'b0;
        ack_o.valid <= 1'b1;
        ack_o.addr <= 16'(2 * k + 2);
        cnt_q <= 4'h0;
      end
      seen_q <= s;
    end
  end
endmodule

// [peripheral_irq_expander_tb.sv]
// Testbench: reference model of the expander checked every cycle
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module peripheral_irq_expander_tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  pie_pkg::source_bus_t src = '0;
  pie_pkg::ack_bus_t ack;
  logic [3:0] wait_q = 4'h2;
  logic [19:0] pend_o, ackb_o, pend, exp_ackb;
  logic [15:0] vec_o, boot_o, exp_vec;
  logic [3:0] req_b_o, exp_req, orv, prev_or, ack_seen, left;
  logic [15:0] codes [20] = '{16'h20, 16'h4, 16'h1, 16'h11, 16'h6, 16'h7, 16'h21, 16'h22,
    16'h23, 16'h27, 16'h28, 16'h29, 16'h2A, 16'h2B, 16'h2C, 16'h2D, 16'h2E, 16'h33, 16'h34,
    16'h35};
  int cnt [4];
  int bad_count = 0;
  int num_checks = 0;
  int i, l, k;
  function automatic int line_of(int b);
    return b < 6 ? 0 : b < 13 ? 1 : b < 17 ? 2 : 3;
  endfunction
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  peripheral_irq_expander i_peripheral_irq_expander (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .src_i(src), .ack_i(ack), .pending_request_bits_o(pend_o), .acknowledge_bits_o(ackb_o),
    .source_vector_register_o(vec_o), .line_req_b_o(req_b_o), .boot_vector_o(boot_o));
  core_model i_core_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .line_req_b_i(req_b_o),
    .wait_i(wait_q), .ack_o(ack));
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      exp_vec = 16'h0;
      exp_ackb = '0;
      exp_req = 4'hF;
      prev_or = 4'h0;
      ack_seen = 4'h0;
      cnt = '{0, 0, 0, 0};
    end else begin
      pend = src.flag & src.enable;
      orv = 4'h0;
      left = 4'h0;
      // A source clearing on its own strobe no longer counts as active
      for (i = 0; i < 20; i++) begin
        if (pend[i]) orv[line_of(i)] = 1'b1;
        if (pend[i] && !exp_ackb[i]) left[line_of(i)] = 1'b1;
      end
      for (l = 0; l < 4; l++) begin
        if (cnt[l] > 0) cnt[l]--;
        else if (orv[l] && (!prev_or[l] || (ack_seen[l] && left[l]))) cnt[l] = 2;
        exp_req[l] = (cnt[l] == 0);
      end
      prev_or = orv;
      ack_seen = 4'h0;
      exp_ackb = '0;
      if (ack.valid && ack.addr inside {16'h2, 16'h4, 16'h6, 16'h8}) begin
        l = ack.addr / 2 - 1;
        ack_seen[l] = 1'b1;
        k = -1;
        for (i = 19; i >= 0; i--) if (pend[i] && line_of(i) == l) k = i;
        exp_vec = (k < 0) ? 16'h0 : codes[k];
        if (k >= 0) exp_ackb[k] = 1'b1;
      end
    end
  end
  always @(negedge clk_i) begin
    if (rst_b_i) begin
      `CHK(pend_o, src.flag & src.enable)
      `CHK(vec_o, exp_vec)
      `CHK(ackb_o, exp_ackb)
      `CHK(req_b_o, exp_req)
      `CHK(boot_o, 16'h0)
    end
  end
  // Peripheral side: flags clear on their acknowledge strobe
  task cyc(input logic [19:0] add, input logic [19:0] drop);
    @(posedge clk_i);
    src.flag <= (src.flag & ~ackb_o & ~drop) | add;
  endtask
  task close_out;
    $display("checks=%0d bad=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #(3000 * 100);
    bad_count++;
    close_out;
  end
  initial begin
    void'($urandom(32'hc0b66ce3));
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    src.enable <= '1;
    for (int s = 0; s < 20; s++) begin
      cyc(20'(1) << s, '0);
      repeat (12) cyc('0, '0);
    end
    $display("test source sweep done checks=%0d", num_checks);
    // Random mix: several per line, late clears give phantom vectors
    for (int n = 0; n < 2000; n++) begin
      wait_q <= 4'($urandom % 6);
      if (n % 50 == 0) src.enable <= 20'($urandom | $urandom);
      cyc(20'($urandom & $urandom & $urandom), 20'($urandom & $urandom & $urandom));
    end
    $display("test random traffic done checks=%0d", num_checks);
    // Reset in mid-run: flags survive it and must raise fresh requests
    rst_b_i <= 1'b0;
    repeat (3) cyc('0, '0);
    rst_b_i <= 1'b1;
    repeat (30) cyc('0, '0);
    $display("test mid-run reset done checks=%0d", num_checks);
    close_out;
  end
endmodule
